/* File: verilog/rslc_pkg.sv */
// Constants, types and state layout of the reset and low-power controller
package rslc_pkg;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_CAUSE = 12'h000;
	localparam logic [11:0] OFF_PWR = 12'h004;
	localparam logic [11:0] OFF_LVCTL = 12'h008;
	localparam logic [11:0] OFF_TRIM = 12'h00C;
	localparam int CAUSE_POR = 7;
	localparam int CAUSE_STOP = 6;
	localparam int CAUSE_WDT = 5;
	localparam int CAUSE_EXT = 4;
	localparam logic [3:0] CAUSE_HI_RST = 4'h8;
	localparam logic [3:0] CAUSE_HI_ALL = 4'hF;
	localparam int LVCTL_IE = 0;
	localparam int LVCTL_BOD_OFF = 1;
	localparam logic [1:0] LVCTL_RST = 2'h0;
	localparam logic [7:0] PWR_RST = 8'h00;
	localparam logic [15:0] TRIM_ADDR = 16'h0003;
	localparam int TRIM_W = 3;
	localparam int FILT_W = 8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		RSLC_RUN,
		RSLC_HALT,
		RSLC_STOP,
		RSLC_RECOVER
	} rslc_mode_t;

	typedef struct packed {
		rslc_mode_t mode;
		logic pin_s1;
		logic pin_s2;
		logic dbg_s1;
		logic dbg_s2;
		logic lv_s1;
		logic lv_s2;
		logic [FILT_W-1:0] filt_cnt;
		logic pin_low;
		logic lv_flag;
		logic [3:0] cause_hi;
		logic [7:0] pwr;
		logic [1:0] lvctl;
		logic [TRIM_W-1:0] trim;
		logic trim_rd;
		logic [15:0] trim_addr;
		logic sys_rst;
		logic cpu_halt;
		logic stopped;
		logic recovered;
		logic lvd_irq;
		logic bod_en;
		logic wdt_wr;
		logic [7:0] wdt_data;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rslc_state_t;

endpackage

/* File: verilog/rslc_ctrl.sv */
// Reset cause, low-supply warning, sleep control and peripheral gating
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module rslc_ctrl #(
	parameter logic [rslc_pkg::FILT_W-1:0] FILT_MIN = 8'h04
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [rslc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Pins and supply comparator
	input wire logic i_reset_pin_n,
	input wire logic i_debug_pin,
	input wire logic i_supply_low,
	// Trim store
	input wire logic [rslc_pkg::TRIM_W-1:0] i_trim_lvd,
	output logic o_trim_rd,
	output logic [15:0] o_trim_addr,
	// CPU core and watchdog
	input wire logic i_halt_req,
	input wire logic i_stop_req,
	input wire logic i_irq_any,
	input wire logic i_wake_gpio,
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_is_reset,
	output logic o_sys_reset,
	output logic o_cpu_halt,
	output logic o_stopped,
	output logic o_recovered,
	output logic o_wdt_ctrl_wr,
	output logic [7:0] o_wdt_ctrl_data,
	// Supply monitor control and interrupt
	output logic o_bod_enable,
	output logic [rslc_pkg::TRIM_W-1:0] o_lvd_threshold,
	output logic o_lvd_irq,
	// Peripheral gating
	output logic [7:0] o_periph_off
);

	// ****************************************
	// State
	// ****************************************
	rslc_pkg::rslc_state_t st;
	rslc_pkg::rslc_state_t next_st;

	// Bus phase decode
	logic setup_rd;
	logic done;
	logic rd_done;
	logic wr_done;
	logic byte0;
	logic ext_evt;
	logic dbg_low;
	logic lv_gated;
	logic [3:0] cause_set;
	logic [3:0] cause_clr;
	logic [7:0] cause_val;

	assign setup_rd = i_psel && !i_penable;
	assign done = i_psel && i_penable && st.pready;
	assign rd_done = done && !i_pwrite;
	assign wr_done = done && i_pwrite;
	assign byte0 = i_pstrb[0];

	// Filtered pin event, debug level, gated comparator
	assign ext_evt = !st.pin_s2 && (st.filt_cnt == FILT_MIN - 1'b1);
	assign dbg_low = !st.dbg_s2;
	assign lv_gated = st.lv_s2 && st.bod_en;

	// Live register image of the reset cause
	assign cause_val = {st.cause_hi, 3'b000, st.lv_flag};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st = st;
		cause_set = 4'h0;
		cause_clr = 4'h0;
		next_st.sys_rst = 1'b0;
		next_st.recovered = 1'b0;
		next_st.lvd_irq = 1'b0;
		next_st.wdt_wr = 1'b0;
		next_st.pready = 1'b0;

		// Two-stage synchronisers
		next_st.pin_s1 = i_reset_pin_n;
		next_st.pin_s2 = st.pin_s1;
		next_st.dbg_s1 = i_debug_pin;
		next_st.dbg_s2 = st.dbg_s1;
		next_st.lv_s1 = i_supply_low;
		next_st.lv_s2 = st.lv_s1;

		// Glitch filter: count consecutive low cycles
		if (st.pin_s2) begin
			next_st.filt_cnt = '0;
			next_st.pin_low = 1'b0;
		end else if (st.filt_cnt != FILT_MIN) begin
			next_st.filt_cnt = st.filt_cnt + 1'b1;
			next_st.pin_low = ext_evt;
		end

		// Trim capture once after reset release
		if (st.trim_rd) begin
			next_st.trim = i_trim_lvd;
			next_st.trim_rd = 1'b0;
		end

		// Live warning flag, no software path
		next_st.lv_flag = lv_gated;
		next_st.bod_en = !st.lvctl[rslc_pkg::LVCTL_BOD_OFF];

		// One-cycle request on rising edge when enabled
		if (lv_gated && !st.lv_flag) begin
			next_st.lvd_irq = st.lvctl[rslc_pkg::LVCTL_IE];
		end

		// Power mode sequencing
		unique case (st.mode)
			rslc_pkg::RSLC_RUN: begin
				if (ext_evt) begin
					next_st.sys_rst = 1'b1;
					cause_set[rslc_pkg::CAUSE_EXT-4] = 1'b1;
				end else if (i_wdt_timeout) begin
					cause_set[rslc_pkg::CAUSE_WDT-4] = 1'b1;
					next_st.sys_rst = i_wdt_is_reset;
				end else if (i_stop_req) begin
					next_st.mode = rslc_pkg::RSLC_STOP;
				end else if (i_halt_req) begin
					next_st.mode = rslc_pkg::RSLC_HALT;
				end
			end
			rslc_pkg::RSLC_HALT: begin
				// Only the CPU stops; clocks keep running
				if (ext_evt) begin
					next_st.sys_rst = 1'b1;
					cause_set[rslc_pkg::CAUSE_EXT-4] = 1'b1;
					next_st.mode = rslc_pkg::RSLC_RUN;
				end else if (i_wdt_timeout) begin
					cause_set[rslc_pkg::CAUSE_WDT-4] = 1'b1;
					next_st.sys_rst = i_wdt_is_reset;
					next_st.mode = rslc_pkg::RSLC_RUN;
				end else if (i_irq_any) begin
					next_st.mode = rslc_pkg::RSLC_RUN;
				end
			end
			rslc_pkg::RSLC_STOP: begin
				if (ext_evt) begin
					next_st.sys_rst = 1'b1;
					cause_set[rslc_pkg::CAUSE_EXT-4] = 1'b1;
					next_st.mode = rslc_pkg::RSLC_RUN;
				end else if (dbg_low) begin
					next_st.sys_rst = 1'b1;
					next_st.mode = rslc_pkg::RSLC_RUN;
				end else if (i_wdt_timeout) begin
					cause_set[rslc_pkg::CAUSE_WDT-4] = 1'b1;
					cause_set[rslc_pkg::CAUSE_STOP-4] = 1'b1;
					next_st.mode = rslc_pkg::RSLC_RECOVER;
				end else if (i_wake_gpio) begin
					cause_set[rslc_pkg::CAUSE_STOP-4] = 1'b1;
					next_st.mode = rslc_pkg::RSLC_RECOVER;
				end
			end
			rslc_pkg::RSLC_RECOVER: begin
				next_st.recovered = 1'b1;
				next_st.mode = rslc_pkg::RSLC_RUN;
			end
		endcase

		// CPU held while not running; stop flag raised only in STOP
		next_st.cpu_halt = (next_st.mode != rslc_pkg::RSLC_RUN);
		next_st.stopped = (next_st.mode == rslc_pkg::RSLC_STOP);

		// Read of the cause word clears its upper bits
		if (rd_done && (i_paddr == rslc_pkg::OFF_CAUSE)) begin
			cause_clr = rslc_pkg::CAUSE_HI_ALL;
		end
		// A new event in the same cycle beats the clear
		next_st.cause_hi = (st.cause_hi & ~cause_clr) | cause_set;

		// Register writes
		if (wr_done && byte0) begin
			unique case (i_paddr)
				rslc_pkg::OFF_CAUSE: begin
					next_st.wdt_wr = 1'b1;
					next_st.wdt_data = i_pwdata[7:0];
				end
				rslc_pkg::OFF_PWR: begin
					next_st.pwr = i_pwdata[7:0];
				end
				rslc_pkg::OFF_LVCTL: begin
					next_st.lvctl = i_pwdata[1:0];
				end
				default: begin
					next_st.wdt_wr = 1'b0;
				end
			endcase
		end

		// Answer in the first access cycle
		if (setup_rd) begin
			next_st.pready = 1'b1;
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h0000_0000;
			unique case (i_paddr)
				rslc_pkg::OFF_CAUSE: begin
					if (!i_pwrite) begin
						next_st.prdata = {24'h00_0000, cause_val};
					end
				end
				rslc_pkg::OFF_PWR: begin
					next_st.prdata = {24'h00_0000, st.pwr};
				end
				rslc_pkg::OFF_LVCTL: begin
					next_st.prdata = {30'h0000_0000, st.lvctl};
				end
				rslc_pkg::OFF_TRIM: begin
					next_st.prdata = {29'h0000_0000, st.trim};
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			st.mode <= rslc_pkg::RSLC_RUN;
			st.pin_s1 <= 1'b1;
			st.pin_s2 <= 1'b1;
			st.dbg_s1 <= 1'b1;
			st.dbg_s2 <= 1'b1;
			st.lv_s1 <= 1'b0;
			st.lv_s2 <= 1'b0;
			st.filt_cnt <= '0;
			st.pin_low <= 1'b0;
			st.lv_flag <= 1'b0;
			st.cause_hi <= rslc_pkg::CAUSE_HI_RST;
			st.pwr <= rslc_pkg::PWR_RST;
			st.lvctl <= rslc_pkg::LVCTL_RST;
			st.trim <= '0;
			st.trim_rd <= 1'b1;
			st.trim_addr <= rslc_pkg::TRIM_ADDR;
			st.sys_rst <= 1'b0;
			st.cpu_halt <= 1'b0;
			st.stopped <= 1'b0;
			st.recovered <= 1'b0;
			st.lvd_irq <= 1'b0;
			st.bod_en <= 1'b1;
			st.wdt_wr <= 1'b0;
			st.wdt_data <= 8'h00;
			st.prdata <= 32'h0000_0000;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_prdata = st.prdata;
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_trim_rd = st.trim_rd;
	assign o_trim_addr = st.trim_addr;
	assign o_sys_reset = st.sys_rst;
	assign o_cpu_halt = st.cpu_halt;
	assign o_stopped = st.stopped;
	assign o_recovered = st.recovered;
	assign o_wdt_ctrl_wr = st.wdt_wr;
	assign o_wdt_ctrl_data = st.wdt_data;
	assign o_bod_enable = st.bod_en;
	assign o_lvd_threshold = st.trim;
	assign o_lvd_irq = st.lvd_irq;
	assign o_periph_off = st.pwr;

endmodule

/* File: tb/rslc_assertions.sv */
// Port checker of the reset and low-power controller
`timescale 1ns/1ps
module rslc_assertions (
	// Clock and reset
	input logic i_ref_clk,
	input logic i_reset,
	// Pins and requests
	input logic i_reset_pin_n,
	input logic i_debug_pin,
	input logic i_stop_req,
	input logic i_irq_any,
	input logic i_wdt_timeout,
	// Outputs
	input logic o_sys_reset,
	input logic o_cpu_halt,
	input logic o_stopped,
	input logic o_recovered,
	input logic o_bod_enable,
	input logic o_lvd_irq,
	input logic [15:0] o_trim_addr
);
	// ********
	// Properties
	// ********
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	// Both pins idle
	logic pins_ok;
	assign pins_ok = i_reset_pin_n && i_debug_pin;
	irq_pulse_a: assert property (o_lvd_irq |=> !o_lvd_irq)
		else $error("irq pulse too long");
	bod_gate_a: assert property (!o_bod_enable && $past(!o_bod_enable) |-> !o_lvd_irq)
		else $error("irq with brownout off");
	trim_addr_a: assert property (o_trim_addr == 16'h0003)
		else $error("bad trim address");
	sleep_halt_a: assert property (o_stopped |-> o_cpu_halt)
		else $error("core runs in sleep");
	stop_enter_a: assert property (
		!o_cpu_halt && i_stop_req && !i_wdt_timeout && pins_ok |=> o_stopped)
		else $error("stop ignored");
	halt_wake_a: assert property (o_cpu_halt && !o_stopped && i_irq_any |=> !o_cpu_halt)
		else $error("halt kept on irq");
	wdt_wake_a: assert property (
		o_stopped && i_wdt_timeout && pins_ok |=> !o_stopped ##1 o_recovered)
		else $error("no watchdog recovery");
	reset_cause_a: assert property (
		o_sys_reset |-> !$past(i_reset_pin_n, 3) || !$past(i_debug_pin, 3) || $past(i_wdt_timeout))
		else $error("reset without cause");
endmodule
bind rslc_ctrl rslc_assertions CHK (.*);

/* File: tb/rslc_cpu_model.sv */
// Behavioural CPU core, watchdog and interrupt controller
`timescale 1ns/1ps
module rslc_cpu_model (
	// Clock and commands
	input logic i_ref_clk,
	input logic [2:0] i_cmd,
	input logic i_lvd_irq,
	// Requests to the controller
	output logic o_halt_req = 0,
	output logic o_stop_req = 0,
	output logic o_wdt_timeout = 0,
	output logic o_wake_gpio = 0,
	output logic o_irq_any = 0,
	// Interrupts taken
	output logic [7:0] o_irq_cnt = 8'h00
);
	// One-cycle pulses a cycle after commands 1 to 4
	always @(posedge i_ref_clk) begin
		o_halt_req <= i_cmd == 3'h1;
		o_stop_req <= i_cmd == 3'h2;
		o_wdt_timeout <= i_cmd == 3'h3;
		o_wake_gpio <= i_cmd == 3'h4;
		if (i_cmd >= 3'h5)
			o_irq_any <= i_cmd[0]; // Level until cleared
		o_irq_cnt <= o_irq_cnt + {7'h00, i_lvd_irq === 1'b1};
	end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the reset and low-power controller
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH %0t %h %h", $time, (a), (e)); end end
module testbench;
	// ********
	// Signals and instances
	// ********
	logic i_ref_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic i_reset_pin_n = 1, i_debug_pin = 1, i_supply_low = 0, i_wdt_is_reset = 0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
	logic [3:0] i_pstrb = 4'hF;
	logic [2:0] i_trim_lvd = 3'h5, cmd = 3'h0, o_lvd_threshold;
	logic o_pready, o_pslverr, o_trim_rd, o_sys_reset, o_cpu_halt, o_stopped, o_recovered;
	logic o_wdt_ctrl_wr, o_bod_enable, o_lvd_irq, i_halt_req, i_stop_req, i_irq_any;
	logic i_wake_gpio, i_wdt_timeout, err;
	logic [7:0] o_wdt_ctrl_data, o_periph_off, irqs;
	logic [15:0] o_trim_addr;
	int bad_count = 0, checked = 0;
	rslc_ctrl #(.FILT_MIN(8'h02)) DUT (.*);
	rslc_cpu_model CPU (.i_ref_clk(i_ref_clk), .i_cmd(cmd), .i_lvd_irq(o_lvd_irq),
		.o_halt_req(i_halt_req), .o_stop_req(i_stop_req), .o_wdt_timeout(i_wdt_timeout),
		.o_wake_gpio(i_wake_gpio), .o_irq_any(i_irq_any), .o_irq_cnt(irqs));
	// 40 MHz clock
	always #12.5 i_ref_clk = ~i_ref_clk;
	// ********
	// Shared tasks
	// ********
	task finish_test;
		$display("checked %0d, bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	task c(input logic [2:0] k);
		cmd <= k;
		w(1);
		cmd <= 3'h0;
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		i_psel <= 1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		w(1);
		i_penable <= 1;
		n = 0;
		do begin
			w(1);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			finish_test;
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		w(1);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0000_0000);
		`CHK(rd, e)
	endtask
	task wait_rst;
		int n;
		n = 0;
		while (o_sys_reset !== 1'b1 && n < 30) begin
			w(1);
			n++;
		end
		`CHK(n < 30, 1'b1)
		if (n >= 30)
			finish_test;
	endtask
	// ********
	// Scenarios
	// ********
	task t_boot;
		`CHK(o_lvd_threshold, 3'h5)
		`CHK(o_trim_rd, 1'b0)
		rdc(12'h000, 32'h0000_0080);
		rdc(12'h000, 32'h0000_0000);
		apb(1, 12'h000, 32'h0000_00A5);
		`CHK(o_wdt_ctrl_wr, 1'b1)
		`CHK(o_wdt_ctrl_data, 8'hA5)
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h00C, 32'h0000_0005);
		$display("boot done");
	endtask
	task t_lvd;
		apb(1, 12'h008, 32'h0000_0001);
		i_supply_low <= 1;
		w(6);
		rdc(12'h000, 32'h0000_0001);
		`CHK(irqs, 8'h01)
		apb(1, 12'h000, 32'h0000_0000);
		rdc(12'h000, 32'h0000_0001);
		i_supply_low <= 0;
		w(6);
		rdc(12'h000, 32'h0000_0000);
		apb(1, 12'h008, 32'h0000_0000);
		i_supply_low <= 1;
		w(6);
		`CHK(irqs, 8'h01)
		apb(1, 12'h008, 32'h0000_0002);
		w(1);
		`CHK(o_bod_enable, 1'b0)
		rdc(12'h000, 32'h0000_0000);
		i_supply_low <= 0;
		w(4);
		apb(1, 12'h008, 32'h0000_0000);
		$display("lvd done");
	endtask
	task t_sleep;
		c(3'h2);
		w(3);
		`CHK({o_cpu_halt, o_stopped}, 2'h3)
		c(3'h3);
		w(3);
		`CHK(o_recovered, 1'b1)
		w(1);
		`CHK({o_cpu_halt, o_stopped}, 2'h0)
		rdc(12'h000, 32'h0000_0060);
		c(3'h2);
		w(3);
		c(3'h4);
		w(4);
		`CHK({o_cpu_halt, o_stopped}, 2'h0)
		rdc(12'h000, 32'h0000_0040);
		i_wdt_is_reset <= 1;
		c(3'h3);
		wait_rst;
		i_wdt_is_reset <= 0;
		rdc(12'h000, 32'h0000_0020);
		c(3'h1);
		w(3);
		`CHK({o_cpu_halt, o_stopped}, 2'h2)
		c(3'h5);
		w(3);
		`CHK(o_cpu_halt, 1'b0)
		c(3'h6);
		w(1);
		$display("sleep done");
	endtask
	task t_pin;
		c(3'h2);
		w(3);
		i_reset_pin_n <= 0;
		w(1);
		i_reset_pin_n <= 1;
		w(8);
		`CHK(o_stopped, 1'b1)
		i_reset_pin_n <= 0;
		wait_rst;
		w(4);
		i_reset_pin_n <= 1;
		w(4);
		rdc(12'h000, 32'h0000_0010);
		c(3'h2);
		w(3);
		i_debug_pin <= 0;
		wait_rst;
		w(4);
		i_debug_pin <= 1;
		w(4);
		rdc(12'h000, 32'h0000_0000);
		$display("pin done");
	endtask
	task t_pwr;
		apb(1, 12'h004, 32'h0000_005A);
		`CHK(o_periph_off, 8'h5A)
		rdc(12'h004, 32'h0000_005A);
		rdc(12'h010, 32'h0000_0000);
		`CHK(err, 1'b1)
		$display("power done");
	endtask
	// Reset, then every scenario
	initial begin
		w(16);
		`CHK(o_trim_rd, 1'b1)
		i_reset <= 0;
		w(2);
		t_boot;
		t_lvd;
		t_sleep;
		t_pin;
		t_pwr;
		finish_test;
	end
endmodule
